/* File: hw/drb_pkg.sv */
package drb_pkg;

  // APB address width and data width
  localparam int unsigned DRB_AW = 8;
  localparam int unsigned DRB_DW = 32;

  // Register indices; byte address is four times the index
  localparam logic [4:0] DRB_IDX_BASIC   = 5'h00;
  localparam logic [4:0] DRB_IDX_CHTYPE  = 5'h04;
  localparam logic [4:0] DRB_IDX_BITS    = 5'h05;
  localparam logic [4:0] DRB_IDX_CHCNT   = 5'h06;
  localparam logic [4:0] DRB_IDX_GRPERR  = 5'h07;
  localparam logic [4:0] DRB_IDX_LOST_A  = 5'h08;
  localparam logic [4:0] DRB_IDX_LOST_B  = 5'h09;
  localparam logic [4:0] DRB_IDX_LOST_C  = 5'h0a;
  localparam logic [4:0] DRB_IDX_LOST_D  = 5'h0b;
  localparam logic [4:0] DRB_IDX_MEAS0   = 5'h0c;
  localparam logic [4:0] DRB_IDX_MEAS1   = 5'h0d;
  localparam logic [4:0] DRB_IDX_MEAS2   = 5'h0e;
  localparam logic [4:0] DRB_IDX_MEAS3   = 5'h0f;
  localparam logic [4:0] DRB_IDX_CTRL    = 5'h10;
  localparam logic [4:0] DRB_IDX_IRQ_STS = 5'h11;
  localparam logic [4:0] DRB_IDX_IRQ_MSK = 5'h12;

  // Constant record contents
  localparam logic [6:0] DRB_CHTYPE_DIN  = 7'h70;
  localparam logic [7:0] DRB_BITS_PER_CH = 8'h08;
  localparam logic [7:0] DRB_CH_COUNT    = 8'h08;

  // Control register fields
  localparam int unsigned DRB_CTRL_PWM   = 0;
  localparam int unsigned DRB_CTRL_MORE  = 1;
  localparam int unsigned DRB_CTRL_CLR   = 2;

  // Interrupt status and mask fields
  localparam int unsigned DRB_EV_GRPERR  = 0;
  localparam int unsigned DRB_EV_LOSTIN  = 1;
  localparam int unsigned DRB_EV_LOSTMS  = 2;
  localparam int unsigned DRB_EV_N       = 3;

  // Reset values
  localparam logic       DRB_RST_PWM   = 1'b0;
  localparam logic       DRB_RST_MORE  = 1'b0;
  localparam logic [2:0] DRB_RST_MASK  = 3'h0;

  // Diagnostic events from the measurement logic, same clock
  typedef struct packed {
    logic [3:0]  grp_err;
    logic [3:0]  fm_err;
    logic [15:0] lost_in;
    logic [3:0]  lost_meas;
  } drb_events_t;

  // Whole state of the record builder
  typedef struct packed {
    logic [31:0] basic;
    logic [7:0]  err;
    logic [15:0] lost_in;
    logic [3:0]  lost_meas;
    logic        pwm;
    logic        more;
    logic [2:0]  sts;
    logic [2:0]  mask;
    logic [31:0] rdata;
    logic        slverr;
    logic        irq;
  } drb_state_t;

endpackage

/* File: hw/drb_record_builder.sv */
// Local design decision: register access over APB.
`timescale 1ns/1ns
module drb_record_builder
(
  // Clock, reset, enable
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               pclken,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [drb_pkg::DRB_AW-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // Record sources
  input  wire logic [31:0]        basic_diag,
  input  wire drb_pkg::drb_events_t diag_events,
  // Interrupt and mode
  output logic                    irq,
  output logic                    mode_pwm
);
  import drb_pkg::*;

  drb_state_t s_reg;
  drb_state_t s_next;

  // Spread four flags onto the even bits of a byte
  function automatic logic [7:0] spread4(input logic [3:0] f);
    spread4 = {1'b0, f[3], 1'b0, f[2], 1'b0, f[1], 1'b0, f[0]};
  endfunction

  // Register index from a byte address, with hit flag in bit 5
  function automatic logic [5:0] decode(input logic [DRB_AW-1:0] a);
    logic ok;
    ok = (a[1:0] == 2'h0) && (a[DRB_AW-1:7] == '0);
    decode = {ok, a[6:2]};
  endfunction

  // Read multiplexer, hit flag in bit 32
  function automatic logic [32:0] rd_word(input drb_state_t s,
                                          input logic [4:0]  idx);
    logic [7:0] b;
    logic       hit;
    b   = 8'h00;
    hit = 1'b1;
    if (idx == DRB_IDX_BASIC)
      rd_word = {1'b1, s.basic};
    else
    begin
      if (idx == DRB_IDX_CHTYPE)
        b = {s.more, DRB_CHTYPE_DIN};
      else if (idx == DRB_IDX_BITS)
        b = DRB_BITS_PER_CH;
      else if (idx == DRB_IDX_CHCNT)
        b = DRB_CH_COUNT;
      else if (idx == DRB_IDX_GRPERR)
      begin
        // Upper nibble only means something while measuring
        b[3:0] = s.err[3:0];
        b[7:4] = s.pwm ? 4'h0 : s.err[7:4];
      end
      else if (idx == DRB_IDX_LOST_A)
        b = spread4(s.lost_in[3:0]);
      else if (idx == DRB_IDX_LOST_B)
        b = spread4(s.lost_in[7:4]);
      else if (idx == DRB_IDX_LOST_C)
        b = spread4(s.lost_in[11:8]);
      else if (idx == DRB_IDX_LOST_D)
        b = spread4(s.lost_in[15:12]);
      else if (idx == DRB_IDX_MEAS0)
        b = {7'h00, s.lost_meas[0] & ~s.pwm};
      else if (idx == DRB_IDX_MEAS1)
        b = {7'h00, s.lost_meas[1] & ~s.pwm};
      else if (idx == DRB_IDX_MEAS2)
        b = {7'h00, s.lost_meas[2] & ~s.pwm};
      else if (idx == DRB_IDX_MEAS3)
        b = {7'h00, s.lost_meas[3] & ~s.pwm};
      else if (idx == DRB_IDX_CTRL)
        b = {6'h00, s.more, s.pwm};
      else if (idx == DRB_IDX_IRQ_STS)
        b = {5'h00, s.sts};
      else if (idx == DRB_IDX_IRQ_MSK)
        b = {5'h00, s.mask};
      else
        hit = 1'b0;
      // Narrow registers sit in the low byte, the rest reads zero
      rd_word = {hit, 24'h000000, b};
    end
  endfunction

  // Reset image of the whole state
  function automatic drb_state_t rst_state();
    drb_state_t r;
    r        = '0;
    r.pwm    = DRB_RST_PWM;
    r.more   = DRB_RST_MORE;
    r.mask   = DRB_RST_MASK;
    rst_state = r;
  endfunction

  // Next-state logic
  always_comb
  begin
    logic [5:0]  dec;
    logic [32:0] rd;
    logic        setup;
    logic        wr;
    logic [7:0]  err_now;
    logic [7:0]  err_rise;
    logic [2:0]  ev_set;
    logic [2:0]  sts_clr;
    logic        lost_clr;
    err_now  = 8'h00;
    err_rise = 8'h00;
    ev_set   = 3'h0;
    dec      = decode(paddr);
    rd       = rd_word(s_reg, dec[4:0]);
    setup    = psel & ~penable;
    wr       = psel & penable & pwrite & ~s_reg.slverr & pstrb[0];
    sts_clr  = 3'h0;
    lost_clr = 1'b0;
    s_next   = s_reg;

    // Keep a registered copy of the basic record
    s_next.basic = basic_diag;

    // Group errors are current levels; meter errors gated by mode
    err_now  = {diag_events.fm_err & {4{~s_reg.pwm}},
                diag_events.grp_err};
    err_rise = err_now & ~s_reg.err;
    s_next.err = err_now;

    // Register writes take effect at the access edge
    if (wr && dec[4:0] == DRB_IDX_CTRL)
    begin
      s_next.pwm  = pwdata[DRB_CTRL_PWM];
      s_next.more = pwdata[DRB_CTRL_MORE];
      lost_clr    = pwdata[DRB_CTRL_CLR];
    end
    else if (wr && dec[4:0] == DRB_IDX_IRQ_STS)
      sts_clr = pwdata[2:0];
    else if (wr && dec[4:0] == DRB_IDX_IRQ_MSK)
      s_next.mask = pwdata[2:0];

    // Sticky lost flags; a new event beats a clear in the same cycle
    s_next.lost_in = (lost_clr ? 16'h0000 : s_reg.lost_in)
                     | diag_events.lost_in;
    // Measurement channels do not exist in pulse width mode
    s_next.lost_meas = (lost_clr ? 4'h0 : s_reg.lost_meas)
                       | (diag_events.lost_meas
                          & {4{~s_reg.pwm}});

    // Interrupt events, write one to clear, set wins
    ev_set                = 3'h0;
    ev_set[DRB_EV_GRPERR] = |err_rise;
    ev_set[DRB_EV_LOSTIN] = |diag_events.lost_in;
    ev_set[DRB_EV_LOSTMS] = |(diag_events.lost_meas & {4{~s_reg.pwm}});
    s_next.sts = (s_reg.sts & ~sts_clr) | ev_set;
    s_next.irq = |(s_next.sts & s_next.mask);

    // Read data and error are captured in the setup cycle; a misaligned
    // or out-of-range address must not alias onto a mapped index
    if (setup)
    begin
      s_next.rdata  = (rd[32] && dec[5] && !pwrite) ? rd[31:0]
                                                    : 32'h00000000;
      s_next.slverr = ~(rd[32] & dec[5]);
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= rst_state();
    else if (pclken)
      s_reg <= s_next;
  end

  // Outputs; one wait-free access phase whenever enabled
  assign pready   = pclken;
  assign prdata   = s_reg.rdata;
  assign pslverr  = psel & penable & s_reg.slverr;
  assign irq      = s_reg.irq;
  assign mode_pwm = s_reg.pwm;

endmodule

/* File: dv/drb_record_builder_sva.sv */
`timescale 1ns/1ns
module drb_record_builder_sva
(
  // Clock and APB
  input logic                           pclk,
  input logic                           presetn,
  input logic                           pclken,
  input logic                           psel,
  input logic                           penable,
  input logic                           pwrite,
  input logic [drb_pkg::DRB_AW-1:0]     paddr,
  input logic [31:0]                    pwdata,
  input logic [3:0]                     pstrb,
  input logic                           pready,
  input logic [31:0]                    prdata,
  // Record source and mode
  input logic [31:0]                    basic_diag,
  input logic                           mode_pwm
);
  import drb_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Read setup and completed write, shared by the properties
  logic rd;
  logic wr;
  logic w0;
  assign rd = psel && !penable && !pwrite && pclken;
  assign wr = psel && penable && pwrite && pready && pstrb[0];
  assign w0 = pwdata[0];
  // Copy lags the source by one cycle, read lands one later
  property p_basic; rd && paddr == 8'h00 |=> prdata == $past(basic_diag, 2);
  endproperty
  a_basic: assert property (p_basic) else $error("word 0 bad");
  property p_type; rd && paddr == 8'h10 |=> prdata[6:0] == 7'h70;
  endproperty
  a_type: assert property (p_type) else $error("type bad");
  property p_bits; rd && paddr == 8'h14 |=> prdata == 32'h08; endproperty
  a_bits: assert property (p_bits) else $error("bits bad");
  property p_cnt; rd && paddr == 8'h18 |=> prdata == 32'h08; endproperty
  a_cnt: assert property (p_cnt) else $error("count bad");
  property p_grp; rd && paddr == 8'h1c |=> prdata[31:8] == 24'h0; endproperty
  a_grp: assert property (p_grp) else $error("byte 7 bad");
  property p_pwm7;
    rd && paddr == 8'h1c && mode_pwm |=> prdata[7:4] == 4'h0;
  endproperty
  a_pwm7: assert property (p_pwm7) else $error("pwm byte 7 bad");
  property p_lost;
    rd && paddr[7:4] == 4'h2 && paddr[1:0] == 2'h0 |=>
      (prdata & 32'hffffffaa) == 32'h0;
  endproperty
  a_lost: assert property (p_lost) else $error("odd bits set");
  property p_meas;
    rd && paddr[7:4] == 4'h3 && paddr[1:0] == 2'h0 |=> prdata[31:1] == 31'h0;
  endproperty
  a_meas: assert property (p_meas) else $error("meas byte bad");
  property p_mode; wr && paddr == 8'h40 |=> mode_pwm == $past(w0);
  endproperty
  a_mode: assert property (p_mode) else $error("mode bad");
endmodule
bind drb_record_builder drb_record_builder_sva u_sva (.pclk, .presetn,
  .pclken, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
  .prdata, .basic_diag, .mode_pwm);

/* File: dv/drb_fw_model.sv */
`timescale 1ns/1ns
module drb_fw_model
(
  // Clock and slave answer
  input  logic        pclk,
  input  logic        pready,
  input  logic [31:0] prdata,
  input  logic        pslverr,
  // Request
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [7:0]  paddr,
  output logic [31:0] pwdata
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // One transfer; idles an edge first so psel never toggles twice a step
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import drb_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        irq, mode_pwm, e, pwm, more;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, basic_diag, rd;
  drb_events_t ev;
  logic [3:0]  g, f, lm;
  logic [15:0] li;
  logic [2:0]  sts, msk;
  int          seed = 32'hfb66;
  int          fail_count, num_checks, i, m, j;
  logic [7:0]  bad [3] = '{8'h4c, 8'h01, 8'h80};

  // Clock enable and strobe held on: every transfer runs at full rate
  drb_record_builder DUT (.pclk, .presetn, .pclken(1'b1), .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb(4'hf), .pready, .prdata, .pslverr,
    .basic_diag, .diag_events(ev), .irq, .mode_pwm);
  drb_fw_model fw (.pclk, .pready, .prdata, .pslverr, .psel, .penable,
    .pwrite, .paddr, .pwdata);

  initial
  begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end

  task automatic chk(string n, logic [31:0] x, logic [31:0] s);
    num_checks++;
    if (s !== x)
    begin
      $display("unexpected %s exp %h got %h", n, x, s);
      fail_count++;
    end
  endtask

  // Reference record built from what the bench drove
  function automatic logic [31:0] ex(int j);
    logic [31:0] v;
    v = '0;
    case (j)
      0: v = basic_diag;
      4: v = {more, 7'h70};
      5, 6: v = 32'h08;
      7: v = {pwm ? 4'h0 : f, g};
      8, 9, 10, 11: for (int b = 0; b < 4; b++) v[2*b] = li[4*(j-8)+b];
      12, 13, 14, 15: v[0] = !pwm && lm[j-12];
      16: v = {30'h0, more, pwm};
      17: v = sts;
      18: v = msk;
      default: v = '0;
    endcase
    return v;
  endfunction

  task wrap_up;
    if (fail_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence: every mode and type flag, events, irq, refusals
  initial
  begin
    presetn = 0;
    ev = '0;
    basic_diag = $random(seed);
    {g, f, lm, li, sts, msk, pwm, more} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    for (m = 0; m < 4; m++)
    begin
      {more, pwm} = m[1:0];
      fw.xfer(1'b1, 8'h40, 32'(m), rd, e);
      fw.xfer(1'b1, 8'h10, 32'hff, rd, e);
      @(posedge pclk);
      {g, f, li, lm} = 28'($random(seed));
      ev <= {g, f, li, lm};
      if (pwm)
        lm = '0;
      sts = {|lm, |li, |g};
      @(posedge pclk);
      ev.lost_in <= '0;
      ev.lost_meas <= '0;
      msk = 3'($random(seed));
      fw.xfer(1'b1, 8'h48, 32'(msk), rd, e);
      chk("mode", 32'(pwm), 32'(mode_pwm));
      for (i = 0; i < 19; i++)
      begin
        if (i inside {[1:3]})
          continue;
        fw.xfer(1'b0, 8'(4*i), 32'h0, rd, e);
        chk("record", ex(i), rd);
      end
      chk("irq", 32'(|(sts & msk)), 32'(irq));
      @(posedge pclk);
      ev <= '0;
      repeat (2) @(posedge pclk);
      fw.xfer(1'b1, 8'h44, 32'h7, rd, e);
      fw.xfer(1'b1, 8'h40, 32'(m | 4), rd, e);
      {sts, li, lm} = '0;
      fw.xfer(1'b0, 8'h44, 32'h0, rd, e);
      chk("sts", 32'h0, rd);
      chk("irq", 32'h0, 32'(irq));
    end
    // Unmapped, misaligned and out-of-range reads are refused
    for (j = 0; j < 3; j++)
    begin
      fw.xfer(1'b0, bad[j], 32'h0, rd, e);
      chk("err", 32'h1, 32'(e));
      chk("err data", 32'h0, rd);
    end
    wrap_up();
  end

  // Watchdog against a hung transfer
  initial
  begin
    #20000;
    fail_count++;
    wrap_up();
  end
endmodule
